/* pin_defaults_regs.vh */
`ifndef PIN_DEFAULTS_REGS_VH
`define PIN_DEFAULTS_REGS_VH
// Function select codes for a line (one of A..H; plain GPIO is a separate mode bit)
`define FUNC_W 3
`define FUNC_A 3'h0
`define FUNC_F 3'h5
`define FUNC_H 3'h7
// Reset values
`define PULLUP_RST_LINE0 1'b1
`define PULLUP_RST_OTHER 1'b0
`define GPIO_EN_RST 1'b0
`define CLKOUT_EN_RST 1'b1
// Line indices within port A
`define LINE_ZERO 0
`define LINE_TWENTY 20
// Stable samples needed before a two-wire input is believed
`define TW_FILT_LEN 3
`endif

/* pin_reset_defaults.v */
// Functional notes
// - JTAG enabled when test clock low at release
// - Pull-ups on TCK, TMS, TDI while JTAG on
// - TCK pull-up always on during reset
// - TDO pure output, never pulled up
// - JTAG off: pins go to GPIO/peripheral mux
// - Two-wire function selected on its pins after reset
// - Two-wire pins open-drain with input spike filter
// - Independent pull-up control bit per line
// - Reset: inputs, pull-ups off except line zero
// - Line twenty defaults to function F
// - Slow RC clock out from power-up
// - Clock out off on other function/GPIO/enable zero
// - Once disabled, clock out stays disabled
// - Alt crystal output does not stop clock out
`timescale 1ns/100ps
`include "pin_defaults_regs.vh"
module pin_reset_defaults #(
  parameter NLINES = 23,
  parameter NTW = 3,
  parameter FILT_LEN = `TW_FILT_LEN
) (
  input wire MCLK,
  input wire RESETN,
  input wire POR_ACTIVE,
  input wire SLOW_RC_CLK,
  input wire TCK_PIN_IN,
  input wire [NLINES-1:0] GPIO_PULLUP_CTRL,
  input wire [NLINES-1:0] GPIO_PULLUP_WR,
  input wire [NLINES-1:0] GPIO_OE_CTRL,
  input wire [NLINES-1:0] GPIO_OE_WR,
  input wire [NLINES-1:0] GPIO_MODE_CTRL,
  input wire [NLINES-1:0] GPIO_MODE_WR,
  input wire [`FUNC_W-1:0] LINE20_FUNC_CTRL,
  input wire LINE20_FUNC_WR,
  input wire SLOW_CLOCK_OUT_ENABLE,
  input wire ALT_CRYSTAL_OUTPUT,
  input wire [NTW-1:0] TW_MODE_CTRL,
  input wire [NTW-1:0] TW_MODE_WR,
  input wire [NTW-1:0] TW_PERIPH_OUT,
  input wire [NTW-1:0] TW_PIN_IN,
  input wire JTAG_TDO,
  input wire JTAG_TDO_EN,
  output reg JTAG_ENABLED,
  output wire TCK_PULLUP,
  output wire TMS_PULLUP,
  output wire TDI_PULLUP,
  output wire TDO_PULLUP,
  output wire TDO_OUT,
  output wire TDO_OE_N,
  output wire JTAG_PINS_TO_MUX,
  output wire [NLINES-1:0] PULLUP_EN,
  output wire [NLINES-1:0] LINE_OUT_EN,
  output wire [NLINES-1:0] LINE_IS_GPIO,
  output wire [`FUNC_W-1:0] LINE20_FUNC,
  output wire SLOW_RC_CLOCK_OUT,
  output wire SLOW_CLOCK_OUT_ACTIVE,
  output wire [NTW-1:0] TW_OUT,
  output wire [NTW-1:0] TW_OE_N,
  output wire [NTW-1:0] TW_IN_FILT,
  output wire [NTW-1:0] TW_SELECTED
);
  reg tck_s1_q;
  reg tck_s2_q;
  reg rst_seen_q;
  reg [NLINES-1:0] pullup_q;
  reg [NLINES-1:0] oe_q;
  reg [NLINES-1:0] gpio_q;
  reg tdo_q;
  reg tdo_oe_n_q;
  reg [`FUNC_W-1:0] func20_q;
  reg clk_en_q;
  reg [NTW-1:0] tw_sel_q;
  wire clk_off_cond;
  integer i;
  integer j;

  // Test clock pin crosses from the board, so two stages first
  always @(posedge MCLK) begin
    tck_s1_q <= TCK_PIN_IN;
    tck_s2_q <= tck_s1_q;
  end

  // Sample on the first edge after release, then hold until next reset
  // A TCK change after release has no effect; only a new reset resamples
  always @(posedge MCLK) begin
    if (!RESETN) begin
      rst_seen_q <= 1'b1;
      JTAG_ENABLED <= 1'b0;
    end else if (rst_seen_q) begin
      rst_seen_q <= 1'b0;
      JTAG_ENABLED <= ~tck_s2_q;
    end
  end

  wire in_reset = ~RESETN | POR_ACTIVE;
  assign TCK_PULLUP = in_reset | JTAG_ENABLED;
  assign TMS_PULLUP = ~in_reset & JTAG_ENABLED;
  assign TDI_PULLUP = ~in_reset & JTAG_ENABLED;
  assign TDO_PULLUP = 1'b0;
  assign TDO_OUT = tdo_q;
  assign TDO_OE_N = tdo_oe_n_q;
  // TDO is retimed so data and enable leave the pad on the same edge;
  // the pad is released in reset so a debugger never sees a stray level
  always @(posedge MCLK) begin
    if (!RESETN) begin
      tdo_q <= 1'b0;
      tdo_oe_n_q <= 1'b1;
    end else begin
      tdo_q <= JTAG_TDO;
      tdo_oe_n_q <= ~(JTAG_ENABLED & JTAG_TDO_EN);
    end
  end
  // Mux owns JTAG pins only when debug port is off
  assign JTAG_PINS_TO_MUX = ~in_reset & ~JTAG_ENABLED;

  // Per-line pull-up, direction and GPIO mode; writes are per-bit strobes
  always @(posedge MCLK) begin
    if (!RESETN) begin
      pullup_q <= {NLINES{`PULLUP_RST_OTHER}};
      pullup_q[`LINE_ZERO] <= `PULLUP_RST_LINE0;
      oe_q <= {NLINES{1'b0}};
      gpio_q <= {NLINES{`GPIO_EN_RST}};
    end else begin
      for (i = 0; i < NLINES; i = i + 1) begin
        if (GPIO_PULLUP_WR[i]) pullup_q[i] <= GPIO_PULLUP_CTRL[i];
        if (GPIO_OE_WR[i]) oe_q[i] <= GPIO_OE_CTRL[i];
        if (GPIO_MODE_WR[i]) gpio_q[i] <= GPIO_MODE_CTRL[i];
      end
    end
  end
  assign PULLUP_EN = pullup_q;
  assign LINE_OUT_EN = oe_q;
  assign LINE_IS_GPIO = gpio_q;

  always @(posedge MCLK) begin
    if (!RESETN) begin
      func20_q <= `FUNC_F;
    end else if (LINE20_FUNC_WR) begin
      func20_q <= LINE20_FUNC_CTRL;
    end
  end
  assign LINE20_FUNC = func20_q;

  // Crystal output is deliberately not a disable term; software must do it
  assign clk_off_cond = (func20_q != `FUNC_F) | gpio_q[`LINE_TWENTY] |
                        ~SLOW_CLOCK_OUT_ENABLE;

  // Sticky off: no reset path re-arms it except the power-on event itself
  always @(posedge MCLK) begin
    if (POR_ACTIVE) begin
      clk_en_q <= `CLKOUT_EN_RST;
    end else if (RESETN && clk_off_cond) begin
      clk_en_q <= 1'b0;
    end
  end
  // Clock is gated straight to the pad so it runs before the core clock logic
  assign SLOW_CLOCK_OUT_ACTIVE = clk_en_q | POR_ACTIVE;
  assign SLOW_RC_CLOCK_OUT = SLOW_RC_CLK & SLOW_CLOCK_OUT_ACTIVE;

  // Two-wire pads come up owned by the two-wire function, not GPIO
  always @(posedge MCLK) begin
    if (!RESETN) begin
      tw_sel_q <= {NTW{1'b1}};
    end else begin
      for (j = 0; j < NTW; j = j + 1) begin
        if (TW_MODE_WR[j]) tw_sel_q[j] <= TW_MODE_CTRL[j];
      end
    end
  end
  assign TW_SELECTED = tw_sel_q;

  // Open-drain when two-wire: only ever pull low
  assign TW_OUT = tw_sel_q & {NTW{1'b0}} | ~tw_sel_q & TW_PERIPH_OUT;
  assign TW_OE_N = ~(tw_sel_q & ~TW_PERIPH_OUT | ~tw_sel_q);

  genvar g;
  generate
    for (g = 0; g < NTW; g = g + 1) begin : gen_tw
      tw_spike_filter #(.LEN(FILT_LEN)) u_filt (
        .clk(MCLK),
        .rst_n(RESETN),
        .bypass(~tw_sel_q[g]),
        .pin(TW_PIN_IN[g]),
        .filt(TW_IN_FILT[g])
      );
    end
  endgenerate
endmodule // pin_reset_defaults

// Majority-free spike filter: output follows input only after LEN stable samples
module tw_spike_filter #(
  parameter LEN = 3
) (
  input wire clk,
  input wire rst_n,
  input wire bypass,
  input wire pin,
  output wire filt
);
  reg s1_q, s2_q;
  reg [LEN-1:0] hist_q;
  reg filt_q;
  always @(posedge clk) begin
    s1_q <= pin;
    s2_q <= s1_q;
  end
  always @(posedge clk) begin
    if (!rst_n) begin
      hist_q <= {LEN{1'b1}};
      filt_q <= 1'b1;
    end else begin
      hist_q <= {hist_q[LEN-2:0], s2_q};
      if (&hist_q) filt_q <= 1'b1;
      else if (~|hist_q) filt_q <= 1'b0;
    end
  end
  // Plain pin behaviour when not in two-wire mode, only synchronised
  assign filt = bypass ? s2_q : filt_q;
endmodule // tw_spike_filter

/* pin_board_model.sv */
`timescale 1ns/100ps
module pin_board_model (
  input wire [2:0] TW_OE_N,
  input wire [2:0] TW_OUT,
  output wire [2:0] TW_PIN_IN
);
  // Bus pull-up wins unless some pad pulls the line low
  assign TW_PIN_IN = ~(~TW_OE_N & ~TW_OUT);
endmodule // pin_board_model

/* pin_reset_defaults_assertions.sv */
`timescale 1ns/100ps
`include "pin_defaults_regs.vh"
module pin_reset_defaults_chk #(parameter NLINES = 23, parameter NTW = 3) (
  input wire MCLK, RESETN, POR_ACTIVE, SLOW_RC_CLK, TCK_PIN_IN, SLOW_CLOCK_OUT_ENABLE,
  input wire JTAG_ENABLED, TCK_PULLUP, TDO_PULLUP, SLOW_RC_CLOCK_OUT, SLOW_CLOCK_OUT_ACTIVE,
  input wire [NLINES-1:0] GPIO_PULLUP_CTRL, GPIO_PULLUP_WR, PULLUP_EN, LINE_OUT_EN, LINE_IS_GPIO,
  input wire [`FUNC_W-1:0] LINE20_FUNC,
  input wire [NTW-1:0] TW_OUT, TW_OE_N, TW_SELECTED
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RESETN);
  sequence s_kill;
    !POR_ACTIVE && (LINE20_FUNC != `FUNC_F || LINE_IS_GPIO[`LINE_TWENTY] || !SLOW_CLOCK_OUT_ENABLE);
  endsequence
  property p_pu; disable iff (1'b0) !RESETN |-> TCK_PULLUP && !TDO_PULLUP; endproperty
  a_pu: assert property (p_pu) else $error("pull-up wrong in reset");
  property p_jen; $rose(RESETN) |=> JTAG_ENABLED == !$past(TCK_PIN_IN, 3); endproperty
  a_jen: assert property (p_jen) else $error("debug enable wrong");
  property p_dflt;
    disable iff (1'b0) !RESETN |=> PULLUP_EN == 1 && LINE_OUT_EN == 0 && LINE_IS_GPIO == 0
      && LINE20_FUNC == `FUNC_F && &TW_SELECTED;
  endproperty
  a_dflt: assert property (p_dflt) else $error("reset default wrong");
  property p_wr;
    |GPIO_PULLUP_WR |=> ((PULLUP_EN ^ $past(GPIO_PULLUP_CTRL)) & $past(GPIO_PULLUP_WR)) == 0;
  endproperty
  a_wr: assert property (p_wr) else $error("pull-up write lost");
  property p_off; s_kill |=> !SLOW_CLOCK_OUT_ACTIVE; endproperty
  a_off: assert property (p_off) else $error("clock out not stopped");
  property p_stk; !SLOW_CLOCK_OUT_ACTIVE ##1 !POR_ACTIVE |-> !SLOW_CLOCK_OUT_ACTIVE; endproperty
  a_stk: assert property (p_stk) else $error("clock out came back");
  property p_por;
    disable iff (1'b0) POR_ACTIVE |-> SLOW_CLOCK_OUT_ACTIVE && SLOW_RC_CLOCK_OUT == SLOW_RC_CLK;
  endproperty
  a_por: assert property (p_por) else $error("no clock out at power-up");
  property p_od; (~TW_OE_N & TW_SELECTED & TW_OUT) == 0; endproperty
  a_od: assert property (p_od) else $error("two-wire pad drives high");
endmodule // pin_reset_defaults_chk
bind pin_reset_defaults pin_reset_defaults_chk #(.NLINES(NLINES), .NTW(NTW)) chk (.*);

/* pin_reset_defaults_bench.sv */
`timescale 1ns/100ps
`include "pin_defaults_regs.vh"
module pin_reset_defaults_bench;
  reg MCLK = 0, RESETN = 0, POR_ACTIVE = 1, SLOW_RC_CLK = 0, TCK_PIN_IN = 0, JTAG_TDO = 0;
  reg LINE20_FUNC_WR = 0, SLOW_CLOCK_OUT_ENABLE = 1, ALT_CRYSTAL_OUTPUT = 0, JTAG_TDO_EN = 0;
  reg [22:0] GPIO_PULLUP_CTRL = 0, GPIO_PULLUP_WR = 0, GPIO_OE_CTRL = 0, GPIO_OE_WR = 0;
  reg [22:0] GPIO_MODE_CTRL = 0, GPIO_MODE_WR = 0, pu_exp, oe_exp;
  reg [2:0] LINE20_FUNC_CTRL = 5, TW_MODE_CTRL = 0, TW_MODE_WR = 0, TW_PERIPH_OUT = 0;
  wire JTAG_ENABLED, TCK_PULLUP, TMS_PULLUP, TDI_PULLUP, TDO_PULLUP, TDO_OUT, TDO_OE_N;
  wire JTAG_PINS_TO_MUX, SLOW_RC_CLOCK_OUT, SLOW_CLOCK_OUT_ACTIVE;
  wire [22:0] PULLUP_EN, LINE_OUT_EN, LINE_IS_GPIO;
  wire [2:0] LINE20_FUNC, TW_OUT, TW_OE_N, TW_IN_FILT, TW_SELECTED, TW_PIN_IN;
  integer seed = 77517, n_errors = 0, num_checks = 0, k, i;
  pin_reset_defaults dut (.*);
  pin_board_model peer (.*);
  always #50 MCLK = ~MCLK;
  always begin
    repeat (15) @(negedge MCLK);
    SLOW_RC_CLK = ~SLOW_RC_CLK;
  end
  function [22:0] upd(input [22:0] cur, input [22:0] ctl, input [22:0] wr);
    upd = (cur & ~wr) | (ctl & wr);
  endfunction
  task chk(input [31:0] got, input [31:0] exp);
    num_checks = num_checks + 1;
    if (got !== exp) begin
      n_errors = n_errors + 1;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wrap_up;
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Code 3 puts line twenty back to function F with the enable bit set
  task kill(input integer c);
    LINE20_FUNC_CTRL = (c == 0) ? `FUNC_A : `FUNC_F;
    LINE20_FUNC_WR = 1;
    GPIO_MODE_CTRL = {2'h0, c == 1, 20'h0};
    GPIO_MODE_WR = 23'h100000;
    SLOW_CLOCK_OUT_ENABLE = (c != 2);
    @(negedge MCLK);
    LINE20_FUNC_WR = 0;
    GPIO_MODE_WR = 0;
  endtask
  initial begin
    #200000;
    n_errors = n_errors + 1;
    wrap_up;
  end
  initial begin
    for (k = 0; k < 2; k = k + 1) begin
      TCK_PIN_IN = k;
      RESETN = 0;
      repeat (6) @(negedge MCLK);
      chk(PULLUP_EN, 23'h1);
      chk({TCK_PULLUP, TDO_PULLUP, LINE20_FUNC, TW_SELECTED}, {2'h2, `FUNC_F, 3'h7});
      RESETN = 1;
      POR_ACTIVE = 0;
      repeat (2) @(negedge MCLK);
      chk({JTAG_ENABLED, TMS_PULLUP, TDI_PULLUP}, {3{~TCK_PIN_IN}});
      chk(JTAG_PINS_TO_MUX, k);
      TCK_PIN_IN = ~TCK_PIN_IN;
      pu_exp = 23'h1;
      oe_exp = 23'h0;
      for (i = 0; i < 30; i = i + 1) begin
        GPIO_PULLUP_CTRL = $random(seed);
        GPIO_PULLUP_WR = $random(seed);
        GPIO_OE_CTRL = $random(seed) | 1;
        GPIO_OE_WR = $random(seed);
        {JTAG_TDO, JTAG_TDO_EN, TW_PERIPH_OUT, TW_MODE_CTRL, TW_MODE_WR} = $random(seed);
        pu_exp = upd(pu_exp, GPIO_PULLUP_CTRL, GPIO_PULLUP_WR);
        oe_exp = upd(oe_exp, GPIO_OE_CTRL, GPIO_OE_WR);
        @(negedge MCLK);
        chk(PULLUP_EN, pu_exp);
        chk(LINE_OUT_EN, oe_exp);
        chk({TDO_OUT, TDO_OE_N}, {JTAG_TDO, ~((k == 0) & JTAG_TDO_EN)});
      end
      GPIO_PULLUP_WR = 0;
      GPIO_OE_WR = 0;
      TW_MODE_WR = 0;
      chk(JTAG_ENABLED, !k);
      // Two-wire pads: steady high, one-cycle glitch rejected, steady low passed
      TW_MODE_CTRL = 3'h7;
      TW_MODE_WR = 3'h7;
      TW_PERIPH_OUT = 3'h7;
      @(negedge MCLK);
      TW_MODE_WR = 0;
      repeat (8) @(negedge MCLK);
      chk({TW_SELECTED, TW_OUT, TW_OE_N, TW_IN_FILT}, {3'h7, 3'h0, 3'h7, 3'h7});
      TW_PERIPH_OUT = 3'h0;
      @(negedge MCLK);
      TW_PERIPH_OUT = 3'h7;
      repeat (8) @(negedge MCLK);
      chk(TW_IN_FILT, 3'h7);
      TW_PERIPH_OUT = 3'h0;
      repeat (8) @(negedge MCLK);
      chk({TW_OUT, TW_OE_N, TW_IN_FILT}, 9'h0);
      TW_MODE_CTRL = 3'h0;
      TW_MODE_WR = 3'h7;
      TW_PERIPH_OUT = 3'h5;
      @(negedge MCLK);
      TW_MODE_WR = 0;
      repeat (3) @(negedge MCLK);
      chk({TW_OUT, TW_OE_N, TW_IN_FILT}, {3'h5, 3'h0, 3'h5});
      if (k == 0) begin
        ALT_CRYSTAL_OUTPUT = 1;
        @(negedge MCLK);
        chk(SLOW_CLOCK_OUT_ACTIVE, 1);
        for (i = 0; i < 3; i = i + 1) begin
          POR_ACTIVE = 1;
          @(negedge MCLK);
          POR_ACTIVE = 0;
          kill(i);
          @(negedge MCLK);
          chk(SLOW_CLOCK_OUT_ACTIVE, 0);
          kill(3);
          @(negedge MCLK);
          chk(SLOW_CLOCK_OUT_ACTIVE, 0);
        end
      end
    end
    wrap_up;
  end
endmodule // pin_reset_defaults_bench
